// *** rtl/byte_stream_if.sv ***
// valid/ready byte stream between the sequencer and its read fifo
interface byte_stream_if #(parameter int unsigned WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : byte_stream_if

// *** rtl/nand_flash_host_interface.sv ***
// host side sequencer driving a byte-wide nand flash through its pins
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module nand_flash_host_interface #(
   parameter int unsigned FIFO_DEPTH = 16
) (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   // operation request
   input  wire logic                        cmd_valid_i,
   output wire logic                        cmd_ready_o,
   input  wire nand_host_pkg::op_t          cmd_op_i,
   input  wire logic [nand_host_pkg::COL_W-1:0] cmd_col_i,
   input  wire logic [nand_host_pkg::ROW_W-1:0] cmd_row_i,
   input  wire logic [nand_host_pkg::LEN_W-1:0] cmd_len_i,
   input  wire logic                        write_enable_i,
   // program data from the user
   input  wire logic                        wr_valid_i,
   output wire logic                        wr_ready_o,
   input  wire logic [7:0]                  wr_data_i,
   // read data to the user
   output wire logic                        rd_valid_o,
   input  wire logic                        rd_ready_i,
   output wire logic [7:0]                  rd_data_o,
   // flash pins
   output wire logic                        cle_o,
   output wire logic                        ale_o,
   output wire logic                        ce_n_o,
   output wire logic                        we_n_o,
   output wire logic                        output_strobe_n_o,
   output wire logic                        wp_n_o,
   output wire logic [7:0]                  byte_port_o,
   output wire logic                        byte_port_oe_o,
   input  wire logic [7:0]                  byte_port_i,
   input  wire logic                        ready_busy_n_i
);
   // ----------------------------------------------------------------
   // state machine and helpers
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_CMD  = 8'h02,
      S_ADDR = 8'h04,
      S_WDAT = 8'h08,
      S_CONF = 8'h10,
      S_WAIT = 8'h20,
      S_GAP  = 8'h40,
      S_RDAT = 8'h80
   } state_t;

   // address byte for cycle idx; bits above the field are driven low
   function automatic logic [7:0] addr_byte(
      input logic [2:0]                      idx,
      input logic [nand_host_pkg::COL_W-1:0] col,
      input logic [nand_host_pkg::ROW_W-1:0] row
   );
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         3'h0:    b = col[7:0];
         3'h1:    b = {3'h0, col[12:8]};
         3'h2:    b = row[7:0];
         3'h3:    b = row[15:8];
         3'h4:    b = {6'h00, row[17:16]};
         default: b = 8'h00;
      endcase
      return b;
   endfunction : addr_byte

   // first command code of each operation
   function automatic logic [7:0] first_code(input nand_host_pkg::op_t op);
      logic [7:0] c;
      case (op)
         nand_host_pkg::OP_READ:   c = nand_host_pkg::CMD_READ_SETUP;
         nand_host_pkg::OP_PROG:   c = nand_host_pkg::CMD_PROG_SETUP;
         nand_host_pkg::OP_ERASE:  c = nand_host_pkg::CMD_ERASE_SET;
         nand_host_pkg::OP_ID:     c = nand_host_pkg::CMD_ID_READ;
         nand_host_pkg::OP_RESET:  c = nand_host_pkg::CMD_RESET;
         default:                  c = nand_host_pkg::CMD_STATUS;
      endcase
      return c;
   endfunction : first_code

   state_t             state_r, state_nxt;
   nand_host_pkg::op_t op_r, op_nxt;
   logic [nand_host_pkg::COL_W-1:0] col_r, col_nxt;
   logic [nand_host_pkg::ROW_W-1:0] row_r, row_nxt;
   logic [nand_host_pkg::LEN_W-1:0] len_r, len_nxt;
   logic [2:0]         idx_r, idx_nxt;
   logic [2:0]         idx_end_r, idx_end_nxt;
   logic [1:0]         ph_r, ph_nxt;
   logic [3:0]         tcnt_r, tcnt_nxt;
   logic               stat_r, stat_nxt;
   logic               wp_r, wp_nxt;
   logic [7:0]         byte_r, byte_nxt;
   logic               wr_take;
   logic               writing;

   // status replies always carry exactly one byte; id replies take the requested length
   localparam logic [nand_host_pkg::LEN_W-1:0] LEN_ONE = 13'h0001;

   byte_stream_if #(.WIDTH(8)) rd_push ();
   byte_stream_if #(.WIDTH(8)) rd_pop ();

   // ----------------------------------------------------------------
   // read fifo; a stalled reader stops the read strobe
   // ----------------------------------------------------------------
   stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .push      (rd_push),
      .pop       (rd_pop)
   );

   // byte is captured at the end of the strobe-low phase
   assign rd_push.valid = (state_r == S_RDAT) &&
                          (ph_r == nand_host_pkg::PH_LOW);
   assign rd_push.data  = byte_port_i;
   assign rd_pop.ready  = rd_ready_i;
   assign rd_valid_o    = rd_pop.valid;
   assign rd_data_o     = rd_pop.data;

   // ----------------------------------------------------------------
   // pin decode
   // ----------------------------------------------------------------
   // decoded from flops only; pins change in the same clock as the state register
   assign writing  = (state_r == S_CMD) || (state_r == S_ADDR) ||
                     (state_r == S_WDAT) || (state_r == S_CONF);
   assign cle_o    = (state_r == S_CMD) || (state_r == S_CONF);
   assign ale_o    = (state_r == S_ADDR);
   assign ce_n_o   = (state_r == S_IDLE);
   assign we_n_o   = !(writing && ph_r == nand_host_pkg::PH_LOW);
   assign output_strobe_n_o = !((state_r == S_RDAT) &&
                                (ph_r == nand_host_pkg::PH_LOW));
   assign byte_port_oe_o = writing;
   assign byte_port_o    = byte_r;
   assign wp_n_o         = wp_r;
   assign cmd_ready_o    = (state_r == S_IDLE);
   assign wr_take   = (state_r == S_WDAT) &&
                      (ph_r == nand_host_pkg::PH_SETUP) &&
                      (len_r != '0);
   assign wr_ready_o = wr_take;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt   = state_r;
      op_nxt      = op_r;
      col_nxt     = col_r;
      row_nxt     = row_r;
      len_nxt     = len_r;
      idx_nxt     = idx_r;
      idx_end_nxt = idx_end_r;
      ph_nxt      = ph_r;
      tcnt_nxt    = tcnt_r;
      stat_nxt    = stat_r;
      byte_nxt    = byte_r;
      wp_nxt      = write_enable_i;
      // generic three-phase strobe stepping
      if (ph_r == nand_host_pkg::PH_LOW)
      begin
         ph_nxt = nand_host_pkg::PH_HOLD;
      end
      case (state_r)
         S_IDLE:
         begin
            ph_nxt = nand_host_pkg::PH_SETUP;
            stat_nxt = 1'b0;
            if (cmd_valid_i)
            begin
               op_nxt  = cmd_op_i;
               // no column move or copy codes: read and program send a full five-cycle address
               col_nxt = cmd_col_i;
               row_nxt = cmd_row_i;
               len_nxt = cmd_len_i;
               // erase sends only the three row cycles
               idx_nxt = (cmd_op_i == nand_host_pkg::OP_ERASE) ?
                         nand_host_pkg::ADDR_ROW :
                         (cmd_op_i == nand_host_pkg::OP_ID) ?
                         nand_host_pkg::ADDR_END :
                         nand_host_pkg::ADDR_FIRST;
               idx_end_nxt = (cmd_op_i == nand_host_pkg::OP_ID) ?
                             nand_host_pkg::ADDR_ID_END :
                             nand_host_pkg::ADDR_END;
               byte_nxt  = first_code(cmd_op_i);
               state_nxt = S_CMD;
            end
         end
         S_CMD:
         begin
            if (ph_r == nand_host_pkg::PH_SETUP)
            begin
               ph_nxt = nand_host_pkg::PH_LOW;
            end
            else if (ph_r == nand_host_pkg::PH_HOLD)
            begin
               ph_nxt = nand_host_pkg::PH_SETUP;
               tcnt_nxt = nand_host_pkg::WHR_CYC;
               if (stat_r || op_r == nand_host_pkg::OP_STATUS)
               begin
                  len_nxt   = LEN_ONE;
                  state_nxt = S_GAP;
               end
               else if (op_r == nand_host_pkg::OP_RESET)
               begin
                  tcnt_nxt  = nand_host_pkg::WB_CYC;
                  state_nxt = S_WAIT;
               end
               else
               begin
                  byte_nxt  = addr_byte(idx_r, col_r, row_r);
                  state_nxt = S_ADDR;
               end
            end
         end
         S_ADDR:
         begin
            if (ph_r == nand_host_pkg::PH_SETUP)
            begin
               ph_nxt = nand_host_pkg::PH_LOW;
            end
            else if (ph_r == nand_host_pkg::PH_HOLD)
            begin
               ph_nxt  = nand_host_pkg::PH_SETUP;
               idx_nxt = idx_r + 3'h1;
               if (idx_r + 3'h1 != idx_end_r)
               begin
                  byte_nxt = addr_byte(idx_r + 3'h1, col_r, row_r);
               end
               else if (op_r == nand_host_pkg::OP_PROG)
               begin
                  state_nxt = S_WDAT;
               end
               else if (op_r == nand_host_pkg::OP_ID)
               begin
                  tcnt_nxt  = nand_host_pkg::WHR_CYC;
                  state_nxt = S_GAP;
               end
               else
               begin
                  byte_nxt = (op_r == nand_host_pkg::OP_ERASE) ?
                             nand_host_pkg::CMD_ERASE_CONF :
                             nand_host_pkg::CMD_READ_START;
                  state_nxt = S_CONF;
               end
            end
         end
         S_WDAT:
         begin
            if (ph_r == nand_host_pkg::PH_SETUP)
            begin
               if (len_r == '0)
               begin
                  byte_nxt  = nand_host_pkg::CMD_PROG_CONF;
                  state_nxt = S_CONF;
               end
               else if (wr_valid_i)
               begin
                  byte_nxt = wr_data_i;
                  ph_nxt   = nand_host_pkg::PH_LOW;
               end
            end
            else if (ph_r == nand_host_pkg::PH_HOLD)
            begin
               ph_nxt  = nand_host_pkg::PH_SETUP;
               len_nxt = len_r - 1'b1;
            end
         end
         S_CONF:
         begin
            if (ph_r == nand_host_pkg::PH_SETUP)
            begin
               ph_nxt = nand_host_pkg::PH_LOW;
            end
            else if (ph_r == nand_host_pkg::PH_HOLD)
            begin
               // busy may take a while to appear after the strobe rise
               ph_nxt    = nand_host_pkg::PH_SETUP;
               tcnt_nxt  = nand_host_pkg::WB_CYC;
               state_nxt = S_WAIT;
            end
         end
         S_WAIT:
         begin
            // strobes stay high until the device reports ready
            if (tcnt_r != '0)
            begin
               tcnt_nxt = tcnt_r - 1'b1;
            end
            else if (ready_busy_n_i)
            begin
               if (op_r == nand_host_pkg::OP_READ)
               begin
                  state_nxt = S_RDAT;
               end
               else if (op_r == nand_host_pkg::OP_RESET)
               begin
                  state_nxt = S_IDLE;
               end
               else
               begin
                  // fetch pass/fail so the user sees bit zero
                  stat_nxt  = 1'b1;
                  byte_nxt  = nand_host_pkg::CMD_STATUS;
                  state_nxt = S_CMD;
               end
            end
         end
         S_GAP:
         begin
            if (tcnt_r != '0)
            begin
               tcnt_nxt = tcnt_r - 1'b1;
            end
            else
            begin
               state_nxt = S_RDAT;
            end
         end
         S_RDAT:
         begin
            if (ph_r == nand_host_pkg::PH_SETUP)
            begin
               if (len_r == '0)
               begin
                  state_nxt = S_IDLE;
               end
               else if (rd_push.ready)
               begin
                  ph_nxt = nand_host_pkg::PH_LOW;
               end
            end
            else if (ph_r == nand_host_pkg::PH_HOLD)
            begin
               ph_nxt  = nand_host_pkg::PH_SETUP;
               len_nxt = len_r - 1'b1;
            end
         end
         default:
         begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state_r   <= S_IDLE;
         op_r      <= nand_host_pkg::OP_READ;
         col_r     <= '0;
         row_r     <= '0;
         len_r     <= '0;
         idx_r     <= '0;
         idx_end_r <= '0;
         ph_r      <= nand_host_pkg::PH_SETUP;
         tcnt_r    <= '0;
         stat_r    <= 1'b0;
         wp_r      <= 1'b0;        // protect while reset is held
         byte_r    <= 8'h00;
      end
      else
      begin
         state_r   <= state_nxt;
         op_r      <= op_nxt;
         col_r     <= col_nxt;
         row_r     <= row_nxt;
         len_r     <= len_nxt;
         idx_r     <= idx_nxt;
         idx_end_r <= idx_end_nxt;
         ph_r      <= ph_nxt;
         tcnt_r    <= tcnt_nxt;
         stat_r    <= stat_nxt;
         wp_r      <= wp_nxt;
         byte_r    <= byte_nxt;
      end
   end
endmodule : nand_flash_host_interface

// *** rtl/nand_host_pkg.sv ***
// shared constants and types for the nand flash host controller
package nand_host_pkg;

   // ----------------------------------------------------------------
   // geometry and address framing
   // ----------------------------------------------------------------
   localparam int unsigned COL_W       = 13;
   localparam int unsigned ROW_W       = 18;
   localparam int unsigned LEN_W       = 13;
   localparam int unsigned PAGE_BYTES  = 4352;
   localparam int unsigned MAIN_BYTES  = 4096;
   localparam int unsigned SPARE_BYTES = 256;
   localparam int unsigned BLK_PAGES   = 64;
   localparam int unsigned NUM_BLOCKS  = 4096;
   localparam logic [2:0]  ADDR_FIRST  = 3'h0;  // column low byte
   localparam logic [2:0]  ADDR_ROW    = 3'h2;  // first row byte
   localparam logic [2:0]  ADDR_END    = 3'h5;  // one past fifth cycle
   localparam logic [2:0]  ADDR_ID_END = 3'h6;  // id read: one zero byte

   // ----------------------------------------------------------------
   // command codes, msb on port line 8
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_START = 8'h30;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
   localparam logic [7:0] CMD_ERASE_SET  = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   localparam logic [7:0] CMD_ID_READ    = 8'h90;
   localparam logic [7:0] CMD_RESET      = 8'hff;

   // ----------------------------------------------------------------
   // timing at the 25 MHz system clock
   // ----------------------------------------------------------------
   localparam int unsigned T_CLK_NS = 40;
   localparam int unsigned T_WB_NS  = 100; // write strobe high to busy
   localparam int unsigned T_WHR_NS = 60;  // write strobe high to read
   localparam logic [3:0] WB_CYC  =
      4'((T_WB_NS + T_CLK_NS - 1) / T_CLK_NS);
   localparam logic [3:0] WHR_CYC =
      4'((T_WHR_NS + T_CLK_NS - 1) / T_CLK_NS);

   // strobe phases of one bus cycle: setup, strobe low, hold high
   localparam logic [1:0] PH_SETUP = 2'h0;
   localparam logic [1:0] PH_LOW   = 2'h1;
   localparam logic [1:0] PH_HOLD  = 2'h2;

   // ----------------------------------------------------------------
   // operations the user may request
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ   = 3'h0,
      OP_PROG   = 3'h1,
      OP_ERASE  = 3'h2,
      OP_STATUS = 3'h3,
      OP_ID     = 3'h4,
      OP_RESET  = 3'h5
   } op_t;

endpackage : nand_host_pkg

// *** rtl/stream_fifo.sv ***
// parameterised synchronous fifo with valid/ready on both sides
module stream_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // streams
   byte_stream_if.sink   push,
   byte_stream_if.source pop
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    wr_nxt;
   logic [AW-1:0]    rd_r;
   logic [AW-1:0]    rd_nxt;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             do_push;
   logic             do_pop;

   // ----------------------------------------------------------------
   // flags and pointer updates
   // ----------------------------------------------------------------
   // full and empty come straight from the occupancy count
   assign push.ready = (cnt_r != (AW+1)'(DEPTH));
   assign pop.valid  = (cnt_r != '0);
   assign pop.data   = mem_r[rd_r];
   assign do_push    = push.valid && push.ready;
   assign do_pop     = pop.valid && pop.ready;

   // next pointers wrap at depth
   always_comb
   begin
      wr_nxt  = wr_r;
      rd_nxt  = rd_r;
      cnt_nxt = cnt_r;
      if (do_push)
      begin
         wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (do_pop)
      begin
         rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
         cnt_nxt = cnt_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // storage is not reset, only the pointers and the count
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
      if (do_push)
      begin
         mem_r[wr_r] <= push.data;
      end
   end
endmodule : stream_fifo

// *** verification/nand_device_model.sv ***
// behavioural byte-wide nand device answering the host pins
module nand_device_model #(
   parameter logic [7:0] ID_CODE = 8'h3c  // arbitrary value
) (
   // strobes and latches
   input  wire logic        cle_i, ale_i, ce_n_i, we_n_i, re_n_i, wp_n_i,
   // port, busy time and answers
   input  wire logic [7:0]  dq_i,
   input  wire logic [31:0] busy_ns_i,
   output logic [7:0]       dq_o,
   output logic             rb_n_o = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  cmd_r = 8'h00;
   logic [7:0]  conf_r = 8'h00; // last confirm code, outlives status reads
   logic [7:0]  ab [5];
   logic [7:0]  out_r = 8'h00, last_d;
   logic [12:0] col_r;
   logic        stat_r = 0, id_r = 0, fail_r = 0, standby;
   int          na = 0, nd = 0, nr = 0;
   // standby only when deselected and not busy
   assign standby = ce_n_i && rb_n_o;
   // released port shows the inverted last byte, so no stale value passes
   assign dq_o = (!ce_n_i && !re_n_i && !cle_i && !ale_i && we_n_i)
      ? out_r : ~out_r;
   task automatic busy(input logic go);
      if (go) begin #40; rb_n_o = 0; #(busy_ns_i); rb_n_o = 1; end
   endtask : busy
   // latch on strobe rise; while busy the only command codes taken are 70, 71 and ff
   always @(posedge we_n_i) if (!ce_n_i && re_n_i) begin
      if (cle_i && !ale_i && (rb_n_o || dq_i inside {8'h70, 8'h71, 8'hff}))
      begin
         cmd_r = dq_i;
         na = 0;
         nr = 0;
         stat_r = 0;
         id_r = 0;
         case (dq_i)
            8'h30: begin col_r = {ab[1][4:0], ab[0]}; busy(1); end
            8'h10, 8'hd0: begin
               conf_r = dq_i;
               fail_r = !wp_n_i;
               busy(wp_n_i);
            end
            8'h70, 8'h71: stat_r = 1;
            8'h90: id_r = 1;
            8'h80: nd = 0;
            8'hff: busy(1);
            default: ;
         endcase
      end
      else if (ale_i && !cle_i && na < 5) begin ab[na] = dq_i; na++; end
      else if (!cle_i && !ale_i && wp_n_i) begin nd++; last_d = dq_i; end
   end
   // each read strobe fall presents the next byte and steps the column
   always @(negedge re_n_i) if (!ce_n_i) begin
      out_r = stat_r ? {1'b0, rb_n_o, 5'h0, fail_r}
         : id_r ? ID_CODE + 8'(nr) : col_r[7:0] ^ 8'h5a;
      col_r++;
      nr++;
   end
endmodule : nand_device_model

// *** verification/nand_flash_host_interface_tb.sv ***
// self-checking bench for the nand flash host controller
module nand_flash_host_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, write_enable_i = 0;
   logic wr_valid_i = 0, rd_ready_i = 0;
   logic [7:0] wr_data_i = 0;
   logic [12:0] cmd_col_i = 0, cmd_len_i = 0;
   logic [17:0] cmd_row_i = 0;
   logic [31:0] busy_ns = 2000;
   nand_host_pkg::op_t cmd_op_i = nand_host_pkg::OP_READ;
   wire logic cmd_ready_o, wr_ready_o, rd_valid_o, cle_o, ale_o, ce_n_o;
   wire logic we_n_o, output_strobe_n_o, wp_n_o, byte_port_oe_o, ready_busy_n_i;
   wire logic [7:0] rd_data_o, byte_port_o, byte_port_i, dev_dq;
   int err_total = 0, n_checks = 0, cyc = 0;
   // host drives the port when enabled, otherwise the device does
   assign byte_port_i = byte_port_oe_o ? byte_port_o : dev_dq;
   nand_flash_host_interface #(.FIFO_DEPTH(16)) dut (.clk_i, .reset_n_i,
      .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_col_i, .cmd_row_i, .cmd_len_i,
      .write_enable_i, .wr_valid_i, .wr_ready_o, .wr_data_i, .rd_valid_o,
      .rd_ready_i, .rd_data_o, .cle_o, .ale_o, .ce_n_o, .we_n_o,
      .output_strobe_n_o, .wp_n_o, .byte_port_o, .byte_port_oe_o,
      .byte_port_i, .ready_busy_n_i);
   nand_device_model dev (.cle_i(cle_o), .ale_i(ale_o), .ce_n_i(ce_n_o),
      .we_n_i(we_n_o), .re_n_i(output_strobe_n_o), .wp_n_i(wp_n_o),
      .dq_i(byte_port_i), .busy_ns_i(busy_ns), .dq_o(dev_dq),
      .rb_n_o(ready_busy_n_i));
   task automatic check(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // idle controller takes the request at the next edge
   task automatic run_op(nand_host_pkg::op_t op, logic [17:0] row,
                         logic [12:0] col, logic [12:0] len);
      int n = 0;
      cmd_op_i <= op;
      cmd_row_i <= row;
      cmd_col_i <= col;
      cmd_len_i <= len;
      cmd_valid_i <= 1'b1;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 5000);
   endtask : run_op
   // ready only inside pop, so status bytes wait in the fifo for us
   task automatic pop(logic [7:0] exp);
      rd_ready_i <= 1'b1;
      do @(posedge clk_i); while (rd_valid_o !== 1'b1 || rd_ready_i !== 1'b1);
      check(rd_data_o, exp);
      rd_ready_i <= 1'b0;
      @(posedge clk_i);
   endtask : pop
   // slow device, user stalled: fifo must refuse after 16 bytes
   task automatic read_fill;
      fork
         run_op(nand_host_pkg::OP_READ, 18'h2a5c3, 13'h10f0, 13'd20);
         begin
            repeat (400) @(posedge clk_i);
            check(dev.nr, 16);
            check(rd_valid_o, 1);
            for (int i = 0; i < 20; i++) pop(8'(13'h10f0 + i) ^ 8'h5a);
         end
      join
      check({dev.ab[1], dev.ab[0]}, 16'h10f0);
      check({dev.ab[4], dev.ab[3], dev.ab[2]}, 24'h02a5c3);
   endtask : read_fill
   task automatic prog;
      busy_ns <= 200;
      write_enable_i <= 1'b1;
      fork
         run_op(nand_host_pkg::OP_PROG, 18'h00040, 13'h0003, 13'd3);
         begin
            for (int i = 0; i < 3; i++) begin
               wr_data_i <= 8'hc0 + 8'(i);
               wr_valid_i <= 1'b1;
               do @(posedge clk_i); while (wr_ready_o !== 1'b1);
            end
            wr_valid_i <= 1'b0;
         end
      join
      pop(8'h40);
      check(dev.nd, 3);
      check(dev.last_d, 8'hc2);
      check(dev.conf_r, 8'h10);
      check({dev.ab[1], dev.ab[0]}, 16'h0003);
   endtask : prog
   // erase refused while protected, then accepted
   task automatic erase;
      for (int w = 0; w < 2; w++) begin
         write_enable_i <= w[0];
         run_op(nand_host_pkg::OP_ERASE, 18'h3ffc0, 13'h0, 13'h0);
         pop(w ? 8'h40 : 8'h41);
         check({dev.ab[2], dev.ab[1], dev.ab[0]}, 24'h03ffc0);
         check(dev.conf_r, 8'hd0);
      end
   endtask : erase
   task automatic misc;
      run_op(nand_host_pkg::OP_STATUS, 18'h0, 13'h0, 13'h1);
      pop(8'h40);
      run_op(nand_host_pkg::OP_ID, 18'h0, 13'h0, 13'h2);
      pop(dev.ID_CODE);
      pop(dev.ID_CODE + 8'h01);
      run_op(nand_host_pkg::OP_RESET, 18'h0, 13'h0, 13'h0);
      check(dev.cmd_r, 8'hff);
      check({ce_n_o, dev.standby}, 2'b11);
   endtask : misc
   initial forever #20 clk_i = ~clk_i;
   // hang guard far above the expected run length
   always @(posedge clk_i) if (++cyc >= 60000) begin
      err_total++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      check(dev.cmd_r, 8'h00);
      read_fill();
      prog();
      erase();
      misc();
      final_report();
   end
endmodule : nand_flash_host_interface_tb

// *** verification/nand_host_asserts.sv ***
// pin-level checks for the nand flash host controller
module nand_host_asserts (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   // flash pins
   input wire logic       cle_o, ale_o, ce_n_o, we_n_o,
   input wire logic       output_strobe_n_o, wp_n_o, byte_port_oe_o,
   input wire logic       ready_busy_n_i,
   input wire logic [7:0] byte_port_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_latch_excl: assert property (!(cle_o && ale_o))
      else $error("both latches high");
   a_latch_select: assert property ((cle_o || ale_o) |-> !ce_n_o)
      else $error("latch cycle without chip select");
   a_strobe_excl: assert property (!(!we_n_o && !output_strobe_n_o))
      else $error("both strobes low");
   a_read_release: assert property (!output_strobe_n_o |->
      !byte_port_oe_o && !cle_o && !ale_o) else $error("port driven in read");
   a_write_pulse: assert property ($fell(we_n_o) |=> $rose(we_n_o))
      else $error("write strobe not one cycle");
   a_write_hold: assert property (!we_n_o |=> $stable(byte_port_o)
      && $stable(cle_o) && $stable(ale_o)) else $error("byte moved at latch");
   a_read_pulse: assert property ($fell(output_strobe_n_o)
      |=> $rose(output_strobe_n_o)) else $error("read strobe not one cycle");
   a_data_protect: assert property ((!we_n_o && !cle_o && !ale_o)
      |-> wp_n_o) else $error("data input while protected");
   a_busy_quiet: assert property ((!ready_busy_n_i && !cle_o)
      |-> we_n_o && output_strobe_n_o) else $error("strobe while busy");
endmodule : nand_host_asserts

bind nand_flash_host_interface nand_host_asserts u_chk (.clk_i, .reset_n_i,
   .cle_o, .ale_o, .ce_n_o, .we_n_o, .output_strobe_n_o, .wp_n_o,
   .byte_port_oe_o, .ready_busy_n_i, .byte_port_o);
